/* File: rtl/abr_pkg.sv */
// Package with constants and routing function for the auxiliary output and bus routing block.
package abr_pkg;

  // ==========================================================================
  // Widths
  localparam int ABR_SEL_W  = 5;
  localparam int ABR_DATA_W = 16;
  localparam int ABR_ADDR_W = 4;
  localparam int ABR_AUX_N  = 4;
  localparam int ABR_BUS_N  = 3;
  localparam int ABR_EVT_N  = 4;
  localparam int ABR_ERR_HI = 13;

  // ==========================================================================
  // Register indices
  localparam logic [3:0] ABR_REG_CTRL    = 4'h0;
  localparam logic [3:0] ABR_REG_STATUS  = 4'h1;
  localparam logic [3:0] ABR_REG_AUX0    = 4'h2;
  localparam logic [3:0] ABR_REG_BUSO0   = 4'h6;
  localparam logic [3:0] ABR_REG_BUSI0   = 4'h9;
  localparam logic [3:0] ABR_REG_ROUTED  = 4'hC;

  // Control register fields.
  localparam int ABR_CTRL_RUN  = 0;
  localparam int ABR_CTRL_SRST = 1;

  // ==========================================================================
  // Source selection codes
  localparam logic [4:0] ABR_SRC_OFF    = 5'h00;
  localparam logic [4:0] ABR_SRC_ERR    = 5'h01;
  localparam logic [4:0] ABR_SRC_EVT1   = 5'h02;
  localparam logic [4:0] ABR_SRC_EVT4   = 5'h05;
  localparam logic [4:0] ABR_SRC_INTERNAL_LINE_ONE   = 5'h14;
  localparam logic [4:0] ABR_SRC_BUS3   = 5'h16;
  localparam logic [4:0] ABR_SRC_MAX    = 5'h16;

  // Values after reset.
  localparam logic [4:0] ABR_AUX1_RST = 5'h14;
  localparam logic [4:0] ABR_AUX2_RST = 5'h15;
  localparam logic [4:0] ABR_AUX3_RST = 5'h16;
  localparam logic [4:0] ABR_AUX4_RST = 5'h00;
  localparam logic [4:0] ABR_BUSO_RST = 5'h00;
  localparam logic [1:0] ABR_BUSI_RST = 2'h0;
  localparam logic [0:0] ABR_RUN_RST  = 1'h0;

  // Bus input actions.
  typedef enum logic [1:0] {
    ABR_ACT_NONE  = 2'h0,
    ABR_ACT_RUN   = 2'h1,
    ABR_ACT_BANK0 = 2'h3,
    ABR_ACT_BANK1 = 2'h2
  } abr_action_t;

  // Picks one source from {bus3..internal_line_one, evt4..evt1, err}; unknown codes give off.
  function automatic logic abr_route(input logic [4:0] sel, input logic [7:0] src);
    logic r;
    r = 1'b0;
    if (sel == ABR_SRC_ERR)
      r = src[0];
    else if (sel >= ABR_SRC_EVT1 && sel <= ABR_SRC_EVT4)
      r = src[3'(sel - ABR_SRC_EVT1) + 3'h1];
    else if (sel >= ABR_SRC_INTERNAL_LINE_ONE && sel <= ABR_SRC_BUS3)
      r = src[3'(sel - ABR_SRC_INTERNAL_LINE_ONE) + 3'h5];
    return r;
  endfunction

endpackage

/* File: rtl/abr_sync.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module abr_sync
  import abr_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] stage;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      stage <= '0;
      dout  <= '0;
    end
    else
    begin
      stage <= din;
      dout  <= stage;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/abr_route_slot.sv */
// One routed output: active selection latched on reload, registered routed value.
`timescale 1ns/10ps
`default_nettype none
module abr_route_slot
  import abr_pkg::*;
#(
  parameter logic [4:0] RST_SEL = 5'h00
)
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       reload,
  input  wire logic [4:0] pend_sel,
  input  wire logic [7:0] sources,
  output var  logic [4:0] act_sel,
  output var  logic       routed
);

  wire logic pick = abr_route(act_sel, sources);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      act_sel <= RST_SEL;
      routed  <= 1'b0;
    end
    else
    begin
      if (reload)
        act_sel <= pend_sel;
      routed <= pick;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/abr_top.sv */
// Auxiliary output and internal bus routing of the host function unit.
//
// Behaviour
// - Controller error source is high when any status bit 0 to 13 is set.
// - Each of four event inputs can be selected as a routing source.
// - Each of three bus inputs can be selected as a routing source.
// - Four auxiliary selections, codes 0 to 22, default 20, 21, 22, 0.
// - Assignment settings are accepted only while operation is stopped.
// - New settings take effect only after software reset or power-up.
// - Three shared single-bit internal buses exist.
// - Units drive buses by output assignments, act on levels by input assignments.
// - Three bus output selections, codes 0 to 22, default 0.
// - A unit reads back the bus value it drives itself.
// - Bus input actions are off without host unit or with distributed placement.
// - Internal lines one and two reach the two expansion terminals.
// - Event inputs can be routed to the unit's own auxiliary outputs.
// - Run/stop bus input: low level runs all channels, high stops them.
// - Bank bus inputs supply bank number bit 0 and bit 1.
`timescale 1ns/10ps
`default_nettype none
module abr_top
  import abr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  input  wire logic [15:0] device_status,
  input  wire logic [3:0]  event_in,
  input  wire logic [2:0]  bus_line_i,
  output var  logic [2:0]  bus_line_o,
  output var  logic [2:0]  bus_line_oe,
  input  wire logic        host_unit_present,
  input  wire logic        distributed_link,
  output var  logic [3:0]  aux_out,
  output var  logic        expansion_terminal_one,
  output var  logic        expansion_terminal_two,
  output var  logic        all_channel_stop,
  output var  logic [1:0]  bank_select,
  output var  logic        operation_running
);

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] event_s;
  logic [2:0] bus_s;
  logic [1:0] strap_s;

  abr_sync #(.W(4)) u_sync_evt (
    .clock (clock),
    .rst_n (rst_n),
    .din   (event_in),
    .dout  (event_s)
  );

  abr_sync #(.W(3)) u_sync_bus (
    .clock (clock),
    .rst_n (rst_n),
    .din   (bus_line_i),
    .dout  (bus_s)
  );

  abr_sync #(.W(2)) u_sync_strap (
    .clock (clock),
    .rst_n (rst_n),
    .din   ({distributed_link, host_unit_present}),
    .dout  (strap_s)
  );

  // ==========================================================================
  // Register file
  logic                 run;
  logic                 reload;
  logic [4:0]           aux_pend [ABR_AUX_N];
  logic [4:0]           buso_pend [ABR_BUS_N];
  logic [1:0]           busi_pend [ABR_BUS_N];
  logic [1:0]           busi_act [ABR_BUS_N];
  logic [4:0]           aux_act [ABR_AUX_N];
  logic [4:0]           buso_act [ABR_BUS_N];
  logic [2:0]           bus_drv;
  logic [15:0]          next_rdata;

  // A write to any assignment is dropped while operation runs.
  wire logic       cfg_open   = !run;
  wire logic       wr_ctrl    = reg_wr && reg_addr == ABR_REG_CTRL;
  wire logic [3:0] aux_idx    = reg_addr - ABR_REG_AUX0;
  wire logic [3:0] buso_idx   = reg_addr - ABR_REG_BUSO0;
  wire logic [3:0] busi_idx   = reg_addr - ABR_REG_BUSI0;
  wire logic       hit_aux    = reg_addr >= ABR_REG_AUX0 && reg_addr < ABR_REG_BUSO0;
  wire logic       hit_buso   = reg_addr >= ABR_REG_BUSO0 && reg_addr < ABR_REG_BUSI0;
  wire logic       hit_busi   = reg_addr >= ABR_REG_BUSI0 && reg_addr < ABR_REG_ROUTED;
  wire logic       wr_cfg     = reg_wr && cfg_open;
  wire logic [4:0] wr_sel     = reg_wdata[4:0];
  wire logic       sel_legal  = wr_sel <= ABR_SRC_MAX;
  wire logic       srst_req   = wr_ctrl && reg_wdata[ABR_CTRL_SRST];

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      run    <= ABR_RUN_RST;
      reload <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        run <= reg_wdata[ABR_CTRL_RUN];
      reload <= srst_req;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aux_pend[0] <= ABR_AUX1_RST;
      aux_pend[1] <= ABR_AUX2_RST;
      aux_pend[2] <= ABR_AUX3_RST;
      aux_pend[3] <= ABR_AUX4_RST;
      for (int i = 0; i < ABR_BUS_N; i++)
      begin
        buso_pend[i] <= ABR_BUSO_RST;
        busi_pend[i] <= ABR_BUSI_RST;
      end
    end
    else if (wr_cfg)
    begin
      if (hit_aux && sel_legal)
        aux_pend[aux_idx[1:0]] <= wr_sel;
      if (hit_buso && sel_legal)
        buso_pend[buso_idx[1:0]] <= wr_sel;
      if (hit_busi)
        busi_pend[busi_idx[1:0]] <= reg_wdata[1:0];
    end
  end

  // Bus input actions are latched on the same reload as the routing.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < ABR_BUS_N; i++)
        busi_act[i] <= ABR_BUSI_RST;
    end
    else if (reload)
    begin
      for (int i = 0; i < ABR_BUS_N; i++)
        busi_act[i] <= busi_pend[i];
    end
  end

  // ==========================================================================
  // Sources and routing
  wire logic       ctrl_err  = |device_status[ABR_ERR_HI:0];
  wire logic [2:0] bus_seen  = bus_s | bus_drv;
  wire logic [7:0] sources   = {bus_seen, event_s, ctrl_err};

  localparam logic [4:0] AUX_RST [ABR_AUX_N] = '{ABR_AUX1_RST, ABR_AUX2_RST,
                                                 ABR_AUX3_RST, ABR_AUX4_RST};

  for (genvar g = 0; g < ABR_AUX_N; g++)
  begin : g_aux
    abr_route_slot #(.RST_SEL(AUX_RST[g])) u_slot (
      .clock    (clock),
      .rst_n    (rst_n),
      .reload   (reload),
      .pend_sel (aux_pend[g]),
      .sources  (sources),
      .act_sel  (aux_act[g]),
      .routed   (aux_out[g])
    );
  end

  for (genvar g = 0; g < ABR_BUS_N; g++)
  begin : g_buso
    abr_route_slot #(.RST_SEL(ABR_BUSO_RST)) u_slot (
      .clock    (clock),
      .rst_n    (rst_n),
      .reload   (reload),
      .pend_sel (buso_pend[g]),
      .sources  (sources),
      .act_sel  (buso_act[g]),
      .routed   (bus_drv[g])
    );
  end

  // Wired-OR bus: a unit only drives while it asserts the line.
  assign bus_line_o  = bus_drv;
  assign bus_line_oe = bus_drv;

  // ==========================================================================
  // Bus input actions
  wire logic host_ok = strap_s[0] && !strap_s[1];

  function automatic logic abr_pick(input abr_action_t act, input logic [2:0] lvl,
                                    input logic [1:0] a0, input logic [1:0] a1,
                                    input logic [1:0] a2);
    return (a0 == act && lvl[0]) || (a1 == act && lvl[1]) || (a2 == act && lvl[2]);
  endfunction

  wire logic next_stop  = host_ok && abr_pick(ABR_ACT_RUN, bus_seen, busi_act[0],
                                              busi_act[1], busi_act[2]);
  wire logic next_bank0 = host_ok && abr_pick(ABR_ACT_BANK0, bus_seen, busi_act[0],
                                              busi_act[1], busi_act[2]);
  wire logic next_bank1 = host_ok && abr_pick(ABR_ACT_BANK1, bus_seen, busi_act[0],
                                              busi_act[1], busi_act[2]);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      all_channel_stop       <= 1'b0;
      bank_select            <= 2'h0;
      expansion_terminal_one <= 1'b0;
      expansion_terminal_two <= 1'b0;
    end
    else
    begin
      all_channel_stop       <= next_stop;
      bank_select            <= {next_bank1, next_bank0};
      expansion_terminal_one <= bus_seen[0];
      expansion_terminal_two <= bus_seen[1];
    end
  end

  assign operation_running = run;

  // ==========================================================================
  // Read path: data stand only in the cycle after the strobe.
  always_comb
  begin
    next_rdata = 16'h0000;
    if (reg_addr == ABR_REG_CTRL)
      next_rdata = {15'h0000, run};
    else if (reg_addr == ABR_REG_STATUS)
      next_rdata = {7'h00, host_ok, bus_seen, event_s, ctrl_err};
    else if (hit_aux)
      next_rdata = {11'h000, aux_pend[aux_idx[1:0]]};
    else if (hit_buso)
      next_rdata = {11'h000, buso_pend[buso_idx[1:0]]};
    else if (hit_busi)
      next_rdata = {14'h0000, busi_pend[busi_idx[1:0]]};
    else if (reg_addr == ABR_REG_ROUTED)
      next_rdata = {9'h000, bus_drv, aux_out};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
  end

  // ==========================================================================
  // Assertions
  sequence s_cfg_write_running;
    reg_wr && run && hit_aux;
  endsequence

  sequence s_soft_reset;
    wr_ctrl && reg_wdata[ABR_CTRL_SRST] ##1 reload;
  endsequence

  property p_err_route;
    @(posedge clock) disable iff (!rst_n)
      aux_act[3] == ABR_SRC_ERR |=> aux_out[3] == $past(|device_status[13:0]);
  endproperty
  a_err_route: assert property (p_err_route) else $error("error source not routed");

  property p_evt_route;
    @(posedge clock) disable iff (!rst_n)
      aux_act[0] == ABR_SRC_EVT1 ##1 aux_act[0] == ABR_SRC_EVT1
        |-> aux_out[0] == $past(event_s[0]);
  endproperty
  a_evt_route: assert property (p_evt_route) else $error("event not routed");

  property p_bus_route;
    @(posedge clock) disable iff (!rst_n)
      aux_act[0] == ABR_SRC_INTERNAL_LINE_ONE |=> aux_out[0] == $past(bus_seen[0]);
  endproperty
  a_bus_route: assert property (p_bus_route) else $error("bus input not routed");

  property p_aux_defaults;
    @(posedge clock)
      $past(!rst_n) && rst_n |-> aux_act[0] == 5'h14 && aux_act[1] == 5'h15
                                 && aux_act[2] == 5'h16 && aux_act[3] == 5'h00;
  endproperty
  a_aux_defaults: assert property (p_aux_defaults) else $error("bad aux default");

  property p_locked_when_running;
    @(posedge clock) disable iff (!rst_n)
      s_cfg_write_running |=> $stable({aux_pend[0], aux_pend[1], aux_pend[2], aux_pend[3]});
  endproperty
  a_locked_when_running: assert property (p_locked_when_running)
    else $error("write accepted while running");

  property p_no_early_effect;
    @(posedge clock) disable iff (!rst_n)
      !reload |=> aux_act[0] == $past(aux_act[0]) && buso_act[2] == $past(buso_act[2]);
  endproperty
  a_no_early_effect: assert property (p_no_early_effect)
    else $error("routing changed without reset");

  property p_reload_takes;
    @(posedge clock) disable iff (!rst_n)
      s_soft_reset |=> aux_act[1] == $past(aux_pend[1]);
  endproperty
  a_reload_takes: assert property (p_reload_takes) else $error("reload not applied");

  property p_buso_defaults;
    @(posedge clock)
      $past(!rst_n) && rst_n |-> buso_act[0] == 5'h00 && bus_drv == 3'h0;
  endproperty
  a_buso_defaults: assert property (p_buso_defaults) else $error("bad bus output default");

  property p_off_code;
    @(posedge clock) disable iff (!rst_n)
      buso_act[1] == ABR_SRC_OFF |=> !bus_line_oe[1];
  endproperty
  a_off_code: assert property (p_off_code) else $error("disabled output driven");

  property p_runstop;
    @(posedge clock) disable iff (!rst_n)
      host_ok && busi_act[2] == ABR_ACT_RUN && bus_seen[2] |=> all_channel_stop;
  endproperty
  a_runstop: assert property (p_runstop) else $error("run/stop not applied");

  property p_no_host;
    @(posedge clock) disable iff (!rst_n)
      !host_ok |=> !all_channel_stop && bank_select == 2'h0;
  endproperty
  a_no_host: assert property (p_no_host) else $error("action without host unit");

  property p_terminal;
    @(posedge clock) disable iff (!rst_n)
      bus_drv[0] |=> expansion_terminal_one;
  endproperty
  a_terminal: assert property (p_terminal) else $error("terminal misses own drive");

endmodule
`default_nettype wire

/* File: dv/abr_bus_partner.sv */
// Model of the basic units that share the three internal lines with the block.
`timescale 1ns/10ps
`default_nettype none
module abr_bus_partner
  import abr_pkg::*;
(
  input  wire logic [2:0] bus_line_o,
  input  wire logic [2:0] bus_line_oe,
  input  wire logic [2:0] unit_drive,
  output var  logic [2:0] bus_line_i
);
  // The lines are wired-OR with a pull-down, so an undriven line reads low.
  always_comb
  begin
    bus_line_i = (bus_line_o & bus_line_oe) | unit_drive;
  end
endmodule
`default_nettype wire

/* File: dv/abr_top_bench.sv */
// Self-checking testbench for the auxiliary output and internal bus routing block.
`timescale 1ns/10ps
`default_nettype none
module abr_top_bench
  import abr_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] device_status = 16'h0000;
  logic [3:0]  event_in = 4'h0;
  logic [2:0]  bus_line_i;
  logic [2:0]  bus_line_o;
  logic [2:0]  bus_line_oe;
  logic [2:0]  unit_drive = 3'h0;
  logic        host_unit_present = 1'b1;
  logic        distributed_link = 1'b0;
  logic [3:0]  aux_out;
  logic        expansion_terminal_one;
  logic        expansion_terminal_two;
  logic        all_channel_stop;
  logic [1:0]  bank_select;
  logic        operation_running;
  int          n_errors = 0;
  int          samples_checked = 0;

  always #5 clock = ~clock;

  abr_top u_abr_top (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .device_status(device_status), .event_in(event_in), .bus_line_i(bus_line_i),
    .bus_line_o(bus_line_o), .bus_line_oe(bus_line_oe),
    .host_unit_present(host_unit_present), .distributed_link(distributed_link),
    .aux_out(aux_out), .expansion_terminal_one(expansion_terminal_one),
    .expansion_terminal_two(expansion_terminal_two),
    .all_channel_stop(all_channel_stop), .bank_select(bank_select),
    .operation_running(operation_running)
  );

  abr_bus_partner u_abr_bus_partner (
    .bus_line_o(bus_line_o), .bus_line_oe(bus_line_oe),
    .unit_drive(unit_drive), .bus_line_i(bus_line_i)
  );

  // ==========================================================================
  // Shared tasks
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Outputs are levels; six cycles cover the three-cycle synchroniser path.
  task automatic settle();
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic soft_reset();
    wr(ABR_REG_CTRL, 16'h0002);
    settle();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_defaults();
    logic [15:0] d;
    for (int i = 0; i < 4; i++)
    begin
      rd(ABR_REG_AUX0 + 4'(i), d);
      chk("aux sel", (i == 3) ? 16'h0000 : 16'h0014 + 16'(i), d);
    end
    for (int i = 0; i < 3; i++)
    begin
      rd(ABR_REG_BUSO0 + 4'(i), d);
      chk("bus out sel", 16'h0000, d);
    end
    rd(4'hD, d);
    chk("unmapped read", 16'h0000, d);
    for (int p = 1; p < 8; p = p * 2)
    begin
      @(posedge clock);
      unit_drive <= 3'(p);
      settle();
      chk("aux from lines", 16'(p), {12'h000, aux_out});
      chk("terminal one", 16'(p & 1), {15'h0, expansion_terminal_one});
      chk("terminal two", 16'((p >> 1) & 1), {15'h0, expansion_terminal_two});
    end
    @(posedge clock);
    unit_drive <= 3'h0;
  endtask

  task automatic t_run_lock();
    logic [15:0] d;
    wr(ABR_REG_CTRL, 16'h0001);
    settle();
    chk("running", 16'h0001, {15'h0, operation_running});
    rd(ABR_REG_CTRL, d);
    chk("ctrl read", 16'h0001, d);
    wr(ABR_REG_AUX0, 16'h0001);
    rd(ABR_REG_AUX0, d);
    chk("locked sel", 16'h0014, d);
    wr(ABR_REG_CTRL, 16'h0000);
    wr(ABR_REG_AUX0, 16'h0017);
    rd(ABR_REG_AUX0, d);
    chk("code above range", 16'h0014, d);
  endtask

  task automatic t_events();
    @(posedge clock);
    event_in <= 4'hF;
    for (int i = 0; i < 4; i++)
      wr(ABR_REG_AUX0 + 4'(i), 16'(ABR_SRC_EVT1) + 16'(i));
    settle();
    chk("before reload", 16'h0000, {12'h000, aux_out});
    soft_reset();
    for (int p = 1; p < 16; p = p * 2)
    begin
      @(posedge clock);
      event_in <= 4'(p);
      settle();
      chk("aux from events", 16'(p), {12'h000, aux_out});
    end
    @(posedge clock);
    event_in <= 4'h0;
  endtask

  task automatic t_error();
    wr(ABR_REG_AUX0 + 4'h3, 16'(ABR_SRC_ERR));
    soft_reset();
    for (int b = 0; b < 16; b++)
    begin
      @(posedge clock);
      device_status <= 16'h0001 << b;
      settle();
      chk("ctrl error", (b <= 13) ? 16'h0001 : 16'h0000, {15'h0, aux_out[3]});
    end
    @(posedge clock);
    device_status <= 16'h0001;
    wr(ABR_REG_AUX0 + 4'h3, 16'h0000);
    soft_reset();
    chk("code zero off", 16'h0000, {15'h0, aux_out[3]});
    @(posedge clock);
    device_status <= 16'h0000;
  endtask

  task automatic t_bus_actions();
    logic [15:0] d;
    for (int i = 0; i < 6; i++)
      wr(ABR_REG_BUSO0 + 4'(i), 16'h0000);
    wr(ABR_REG_BUSO0 + 4'h2, 16'(ABR_SRC_EVT1));
    wr(ABR_REG_BUSO0, 16'(ABR_SRC_EVT1) + 16'h0001);
    wr(ABR_REG_BUSI0 + 4'h2, 16'(ABR_ACT_RUN));
    wr(ABR_REG_BUSI0, 16'(ABR_ACT_BANK0));
    wr(ABR_REG_BUSI0 + 4'h1, 16'(ABR_ACT_BANK1));
    wr(ABR_REG_AUX0 + 4'h2, 16'(ABR_SRC_BUS3));
    soft_reset();
    chk("run all", 16'h0000, {15'h0, all_channel_stop});
    @(posedge clock);
    event_in <= 4'h1;
    settle();
    chk("bus drive", 16'h0044, {9'h0, bus_line_oe, 1'b0, bus_line_o});
    chk("stop all", 16'h0001, {15'h0, all_channel_stop});
    chk("readback", 16'h0001, {15'h0, aux_out[2]});
    rd(ABR_REG_ROUTED, d);
    chk("routed reg", 16'h0045, d);
    rd(ABR_REG_STATUS, d);
    chk("status reg", 16'h0182, d);
    @(posedge clock);
    event_in <= 4'h2;
    settle();
    chk("bank bit0", 16'h0001, {14'h0, bank_select});
    chk("terminal one", 16'h0001, {15'h0, expansion_terminal_one});
    @(posedge clock);
    unit_drive <= 3'h2;
    settle();
    chk("bank both", 16'h0003, {14'h0, bank_select});
    @(posedge clock);
    unit_drive <= 3'h6;
    distributed_link <= 1'b1;
    settle();
    chk("distributed", 16'h0000, {13'h0, all_channel_stop, bank_select});
    @(posedge clock);
    distributed_link <= 1'b0;
    host_unit_present <= 1'b0;
    settle();
    chk("no host unit", 16'h0000, {13'h0, all_channel_stop, bank_select});
    @(posedge clock);
    host_unit_present <= 1'b1;
    unit_drive <= 3'h0;
    event_in <= 4'h0;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_defaults();
    t_run_lock();
    t_events();
    t_error();
    t_bus_actions();
    results();
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
